// ==== pcfg_regs.sv ====
// Purpose: pci configuration header registers (status/command, class/revision, header/misc)
// Assumes: pci clock and pci events sampled on ref_clk; load window/pending from same clock
// Notes: registers hidden in satellite mode; status mirror offered on a port
// Operation
// (R1) parity_error_seen sets on read-initiator, write-target data or address parity error.
// (R2) system_error_raised sets whenever SERR* is driven active.
// (R3) master_abort_got sets on own initiator master abort, except special cycles.
// (R4) target_abort_got sets when our initiated transfer is target aborted.
// (R5) target_abort_issued sets when we, as target, target abort.
// (R6) status flags reset to zero; write one clears, zero keeps.
// (R7) devsel_speed reads medium; target claims within medium decode timing.
// (R8) initiator_parity_flag needs master role, PERR* seen and parity response enabled.
// (R9) back_to_back_capable one, high_speed_capable zero, capability_list_present one.
// (R10) fast back-to-back issued only with back_to_back_enable; resets zero.
// (R11) SERR* driven only with system_error_enable and parity_response_enable set.
// (R12) parity_response_enable clear: no PERR*/SERR*, transfer continues normally.
// (R13) memory write and invalidate used only with write_invalidate_enable; resets zero.
// (R14) bus_master_enable resets one only in pci boot host mode; gates initiator.
// (R15) memory and io target responses gated by their enables; both reset zero.
// (R16) stepping, palette snoop, special cycle, self test, multi-function bits read zero.
// (R17) class code and revision change only via load word1 during load window.
// (R18) class code resets to host bridge value; revision to undisclosed value.
// (R19) header registers unreachable in satellite mode; status mirrored elsewhere.
// (R20) header_layout resets type 0; loads from load word3 while pending.
// (R21) latency_timer low bits zero; ends own access that many clocks after GNT* loss.
// (R22) cache_line_size resets zero, writable, selects burst read command.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module pcfg_regs
	import pcfg_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// controller mode, same clock
	input wire logic satellite_mode,
	input wire logic config_load_window,
	input wire logic config_load_pending,
	// pci side inputs, asynchronous
	input wire logic pci_clk,
	input wire logic rd_perr_init,
	input wire logic wr_perr_tgt,
	input wire logic addr_perr,
	input wire logic spc_perr,
	input wire logic master_abort,
	input wire logic abort_was_special,
	input wire logic tgt_abort_rx,
	input wire logic tgt_abort_tx,
	input wire logic perr_as_master,
	input wire logic own_access,
	input wire logic gnt_n,
	// straps
	input wire logic boot_pci,
	input wire logic host_mode,
	// pci side controls and satellite status mirror
	output logic serr_n_oe,
	output logic perr_n_oe,
	output logic end_access,
	output logic bus_master_on,
	output logic mem_space_on,
	output logic io_space_on,
	output logic fast_b2b_on,
	output logic mwi_on,
	output logic [7:0] cache_line_size,
	output logic [15:0] sat_status
);

	pcfg_state_t state_reg;
	pcfg_state_t state_next;
	pcfg_pin_t pins;
	logic pci_edge;
	logic wr_stat_cmd;
	logic wr_cr;
	logic wr_hm;
	logic [7:0] sts_set;
	logic [7:0] sts_clr;
	logic [31:0] sts_word;
	logic par_resp_on;
	logic serr_cond;

	////////////////////////////////////////////////////////////////////////////
	// input capture
	always_comb begin
		pins.clk = pci_clk;
		pins.rd_perr_init = rd_perr_init;
		pins.wr_perr_tgt = wr_perr_tgt;
		pins.addr_perr = addr_perr;
		pins.spc_perr = spc_perr;
		pins.master_abort = master_abort;
		pins.abort_was_special = abort_was_special;
		pins.tgt_abort_rx = tgt_abort_rx;
		pins.tgt_abort_tx = tgt_abort_tx;
		pins.perr_as_master = perr_as_master;
		pins.own_access = own_access;
		pins.gnt_n = gnt_n;
		pins.boot_pci = boot_pci;
		pins.host_mode = host_mode;
	end

	assign pci_edge = state_reg.s2.clk & ~state_reg.s3.clk;
	assign par_resp_on = state_reg.cmd[B_PER_EN];
	// accesses are dropped in satellite mode
	assign wr_stat_cmd = reg_wr & ~satellite_mode & (reg_addr == ADDR_STATUS_CMD); // R19
	assign wr_cr = reg_wr & ~satellite_mode & (reg_addr == ADDR_LOAD_WORD1) & config_load_window;
	assign wr_hm = reg_wr & ~satellite_mode & (reg_addr == ADDR_HDR_MISC);
	assign serr_cond = state_reg.s2.addr_perr | state_reg.s2.spc_perr;

	////////////////////////////////////////////////////////////////////////////
	// status event sets, flag byte holds status bits 31:27, two zeros, then 24
	always_comb begin
		sts_set = 8'h00;
		if (pci_edge) begin
			sts_set[7] = state_reg.s2.rd_perr_init | state_reg.s2.wr_perr_tgt
				| state_reg.s2.addr_perr; // R1
			sts_set[6] = serr_cond & par_resp_on & state_reg.cmd[B_SERR_EN]; // R2 R11 R12
			sts_set[5] = state_reg.s2.master_abort & ~state_reg.s2.abort_was_special; // R3
			sts_set[4] = state_reg.s2.tgt_abort_rx; // R4
			sts_set[3] = state_reg.s2.tgt_abort_tx; // R5
			sts_set[0] = state_reg.s2.perr_as_master & par_resp_on; // R8
		end
		sts_clr = wr_stat_cmd ? {reg_wdata[31:27], 2'b00, reg_wdata[24]} : 8'h00;
		sts_word = STATUS_FIXED
			| {state_reg.sts[7:3], 2'b00, state_reg.sts[0], 24'h000000}; // R7 R9
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.s1 = pins;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		// set wins over a same-cycle clear
		state_next.sts = (state_reg.sts & ~sts_clr) | sts_set; // R6
		if (wr_stat_cmd) begin
			state_next.cmd = (reg_wdata[15:0] & CMD_RW_MASK)
				| (state_reg.cmd & ~CMD_RW_MASK); // R10 R13 R15 R16
		end
		if (wr_stat_cmd) begin
			state_next.bm_written = 1'b1;
		end
		// bus master default follows boot straps once they are settled
		if (state_reg.strap_cnt != STRAP_WAIT) begin
			state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
			if ((state_reg.strap_cnt + 2'h1 == STRAP_WAIT) && !state_reg.bm_written
					&& !wr_stat_cmd) begin
				state_next.cmd[B_BUS_MASTER] = state_reg.s2.boot_pci
					& state_reg.s2.host_mode; // R14
			end
		end
		if (wr_cr) begin
			state_next.class_code = reg_wdata[31:8]; // R17
			state_next.rev = reg_wdata[7:0]; // R17
		end
		if (reg_wr && !satellite_mode && (reg_addr == ADDR_LOAD_WORD3)
				&& config_load_pending) begin
			state_next.hdr = reg_wdata[HDR_LSB +: 7]; // R20
		end
		if (wr_hm) begin
			state_next.lat = reg_wdata[LAT_LSB +: 8] & LAT_RW_MASK; // R21
			state_next.line_size = reg_wdata[7:0]; // R22
		end
		// pci side drives, held for one pci clock
		if (pci_edge) begin
			state_next.serr_oe = serr_cond & par_resp_on & state_reg.cmd[B_SERR_EN]; // R11 R12
			state_next.perr_oe = (state_reg.s2.rd_perr_init | state_reg.s2.wr_perr_tgt)
				& par_resp_on; // R12
			// latency expiry after grant loss during own access
			if (!state_reg.s2.own_access) begin
				state_next.lat_cnt = 8'h00;
				state_next.end_access = 1'b0;
			end else if (state_reg.s2.gnt_n && !state_reg.end_access) begin
				state_next.lat_cnt = state_reg.lat_cnt + 8'h01;
				state_next.end_access = (state_reg.lat_cnt + 8'h01 >= state_reg.lat); // R21
			end
		end
		// read data stands in the cycle after the strobe only
		state_next.rdata = 32'h00000000;
		if (reg_rd && !satellite_mode) begin // R19
			case (reg_addr)
				ADDR_STATUS_CMD: state_next.rdata = sts_word | {16'h0000, state_reg.cmd}; // R16
				ADDR_CLASS_REV: state_next.rdata = {state_reg.class_code, state_reg.rev};
				ADDR_HDR_MISC: state_next.rdata = {9'h000, state_reg.hdr, state_reg.lat,
					state_reg.line_size}; // R16
				default: state_next.rdata = 32'h00000000;
			endcase
		end
		state_next.sat_status = sts_word[31:16]; // R19
		if (!rst_n) begin
			state_next = '0;
			state_next.cmd = CMD_RESET; // R10 R11 R13 R15
			state_next.class_code = CLASS_RESET; // R18
			state_next.rev = REV_RESET; // R18
			state_next.hdr = HDR_RESET; // R20
			state_next.lat = LAT_RESET;
			state_next.line_size = LINE_SIZE_RESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign reg_rdata = state_reg.rdata;
	assign serr_n_oe = state_reg.serr_oe;
	assign perr_n_oe = state_reg.perr_oe;
	assign end_access = state_reg.end_access;
	assign bus_master_on = state_reg.cmd[B_BUS_MASTER]; // R14
	assign mem_space_on = state_reg.cmd[B_MEM]; // R15
	assign io_space_on = state_reg.cmd[B_IO]; // R15
	assign fast_b2b_on = state_reg.cmd[B_FBB_EN]; // R10
	assign mwi_on = state_reg.cmd[B_MWI_EN]; // R13
	assign cache_line_size = state_reg.line_size; // R22
	assign sat_status = state_reg.sat_status;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_parity_seen_set: assert property ( // R1
		pci_edge && state_reg.s2.addr_perr |=> state_reg.sts[7])
		else $error("address parity error did not set parity_error_seen");

	chk_serr_gating: assert property ( // R11
		$rose(state_reg.serr_oe) |-> $past(par_resp_on) && $past(state_reg.cmd[B_SERR_EN])
			&& state_reg.sts[6])
		else $error("serr driven without both enables or without flag");

	chk_master_abort: assert property ( // R3
		pci_edge && state_reg.s2.master_abort && !state_reg.s2.abort_was_special
		|=> state_reg.sts[5])
		else $error("master abort not recorded");

	chk_tabort_got: assert property ( // R4
		pci_edge && state_reg.s2.tgt_abort_rx |=> state_reg.sts[4])
		else $error("received target abort not recorded");

	chk_tabort_issued: assert property ( // R5
		pci_edge && state_reg.s2.tgt_abort_tx |=> state_reg.sts[3])
		else $error("issued target abort not recorded");

	chk_w1c_clear: assert property ( // R6
		wr_stat_cmd && reg_wdata[B_TABORT_GOT] && !sts_set[4] |=> !state_reg.sts[4])
		else $error("write one did not clear flag");

	chk_init_par_gate: assert property ( // R8
		!state_reg.sts[0] && !par_resp_on |=> !state_reg.sts[0])
		else $error("initiator parity flag set with parity response off");

	chk_fixed_bits: assert property ( // R9
		reg_rd && !satellite_mode && reg_addr == ADDR_STATUS_CMD
		|=> reg_rdata[26:25] == 2'b01 && reg_rdata[23:20] == 4'h9 && reg_rdata[7] == 1'b0
			&& reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0)
		else $error("fixed status bits read wrong");

	chk_sat_hidden: assert property ( // R19
		reg_rd && satellite_mode |=> reg_rdata == 32'h00000000)
		else $error("register readable in satellite mode");

	chk_class_lock: assert property ( // R17
		!config_load_window && !$past(config_load_window) |=> $stable(state_reg.class_code))
		else $error("class code changed outside load window");

	chk_lat_low_zero: assert property ( // R21
		state_reg.lat[1:0] == 2'b00)
		else $error("latency timer low bits not zero");

	chk_access_end: assert property ( // R21
		$rose(state_reg.end_access) |-> $past(state_reg.s2.own_access)
			&& $past(state_reg.s2.gnt_n) && $past(pci_edge))
		else $error("access ended without own access and grant loss");

endmodule : pcfg_regs

// ==== pcfg_pkg.sv ====
// Purpose: constants and types for the pci configuration header register bank
// Assumes: 32-bit register port, byte addresses as printed
// Notes: revision reset value is arbitrary
package pcfg_pkg;
	// register byte addresses
	localparam logic [15:0] ADDR_STATUS_CMD = 16'hd004;
	localparam logic [15:0] ADDR_CLASS_REV = 16'hd008;
	localparam logic [15:0] ADDR_HDR_MISC = 16'hd00c;
	localparam logic [15:0] ADDR_LOAD_WORD1 = 16'hd1e4;
	localparam logic [15:0] ADDR_LOAD_WORD3 = 16'hd1ec;
	// status/command field positions
	localparam int B_PAR_SEEN = 31;
	localparam int B_SYS_ERR = 30;
	localparam int B_MABORT_GOT = 29;
	localparam int B_TABORT_GOT = 28;
	localparam int B_TABORT_SENT = 27;
	localparam int B_INIT_PAR = 24;
	localparam int B_FBB_EN = 9;
	localparam int B_SERR_EN = 8;
	localparam int B_PER_EN = 6;
	localparam int B_MWI_EN = 4;
	localparam int B_BUS_MASTER = 2;
	localparam int B_MEM = 1;
	localparam int B_IO = 0;
	// fixed status bits: devsel medium, b2b capable, no 66 MHz, capability list
	localparam logic [31:0] STATUS_FIXED = 32'h02900000;
	localparam logic [31:0] STATUS_W1C_MASK = 32'hf9000000;
	localparam logic [15:0] CMD_RW_MASK = 16'h0357;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	// class/revision reset values
	localparam logic [23:0] CLASS_RESET = 24'h060000;
	localparam logic [7:0] REV_RESET = 8'h00;
	// header/misc fields
	localparam logic [6:0] HDR_RESET = 7'h00;
	localparam int HDR_LSB = 16;
	localparam int LAT_LSB = 8;
	localparam logic [7:0] LAT_RW_MASK = 8'hfc;
	localparam logic [7:0] LAT_RESET = 8'h00;
	localparam logic [7:0] LINE_SIZE_RESET = 8'h00;
	// strap capture delay after reset release, covers the synchroniser
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// pci-side inputs, all sampled across the domain
	typedef struct packed {
		logic clk;
		logic rd_perr_init;
		logic wr_perr_tgt;
		logic addr_perr;
		logic spc_perr;
		logic master_abort;
		logic abort_was_special;
		logic tgt_abort_rx;
		logic tgt_abort_tx;
		logic perr_as_master;
		logic own_access;
		logic gnt_n;
		logic boot_pci;
		logic host_mode;
	} pcfg_pin_t;

	typedef struct packed {
		pcfg_pin_t s1;
		pcfg_pin_t s2;
		pcfg_pin_t s3;
		logic [7:0] sts;
		logic [15:0] cmd;
		logic [23:0] class_code;
		logic [7:0] rev;
		logic [6:0] hdr;
		logic [7:0] lat;
		logic [7:0] line_size;
		logic [7:0] lat_cnt;
		logic end_access;
		logic serr_oe;
		logic perr_oe;
		logic [1:0] strap_cnt;
		logic bm_written;
		logic [31:0] rdata;
		logic [15:0] sat_status;
	} pcfg_state_t;
endpackage : pcfg_pkg

// ==== pcfg_pci_agent.sv ====
// Purpose: behavioural pci-side agent that feeds bus events to the header registers
// Assumes: free running pci clock with a 400 ns period
// Notes: an event is held while requested and for two more pci periods after that
`timescale 1ns/100ps
module pcfg_pci_agent
	import pcfg_pkg::*;
(
	// request from the bench
	input wire pcfg_pin_t ev_req,
	input wire logic ev_go,
	// pci side
	output pcfg_pin_t pins,
	output logic busy
);
	logic pci_clk = 1'b0;
	logic [1:0] tail = 2'h0;
	pcfg_pin_t held = '0;

	initial forever #200 pci_clk = ~pci_clk;

	// levels move on the falling edge so each rising edge sees them settled
	always @(negedge pci_clk) begin
		if (ev_go) begin
			held <= ev_req;
			tail <= 2'h2;
		end else if (tail != 2'h0)
			tail <= tail - 2'h1;
		else
			held <= '0;
	end

	always_comb begin
		pins = held;
		pins.clk = pci_clk;
	end
	assign busy = ev_go | (tail != 2'h0) | (held != '0);
endmodule : pcfg_pci_agent

// ==== tb.sv ====
// Purpose: self-checking bench for the pci configuration header register bank
// Assumes: pci events come from the agent model; straps select pci boot in host mode until host_mode is cleared for the second reset
// Notes: read data are checked by a monitor against a queue of expected words
`timescale 1ns/100ps
module tb
	import pcfg_pkg::*;
();
	// event, command, expected status byte 31:24
	localparam logic [37:0] EV_TBL [13] = '{
		{14'h0400, 16'h0140, 8'hc0}, {14'h0400, 16'h0000, 8'h80}, {14'h0400, 16'h0100, 8'h80},
		{14'h1000, 16'h0000, 8'h80}, {14'h0800, 16'h0040, 8'h80}, {14'h0200, 16'h0140, 8'h40},
		{14'h0100, 16'h0000, 8'h20}, {14'h0180, 16'h0000, 8'h00}, {14'h0040, 16'h0000, 8'h10},
		{14'h0020, 16'h0000, 8'h08}, {14'h0010, 16'h0140, 8'h01}, {14'h0010, 16'h0000, 8'h00},
		{14'h0010, 16'h0040, 8'h01}};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, satellite_mode = 1'b0, ev_go = 1'b0, rd_seen = 1'b0;
	logic config_load_window = 1'b0, config_load_pending = 1'b0;
	logic boot_pci = 1'b1, host_mode = 1'b1;
	logic [31:0] reg_rdata, st, r1, r2, r3;
	logic serr_n_oe, perr_n_oe, end_access, bus_master_on, mem_space_on, io_space_on;
	logic fast_b2b_on, mwi_on, busy, sv, pv;
	logic [7:0] cache_line_size;
	logic [15:0] sat_status;
	logic [15:0] seed = 16'hfaba;
	logic [37:0] t;
	pcfg_pin_t ev_req = '0, pins;
	logic [31:0] exp_q[$];
	int mismatches = 0, tests_run = 0, cyc = 0;

	initial forever #25 ref_clk = ~ref_clk;

	pcfg_regs u_pcfg_regs (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.satellite_mode(satellite_mode), .config_load_window(config_load_window),
		.config_load_pending(config_load_pending), .pci_clk(pins.clk),
		.rd_perr_init(pins.rd_perr_init), .wr_perr_tgt(pins.wr_perr_tgt),
		.addr_perr(pins.addr_perr), .spc_perr(pins.spc_perr), .master_abort(pins.master_abort),
		.abort_was_special(pins.abort_was_special), .tgt_abort_rx(pins.tgt_abort_rx),
		.tgt_abort_tx(pins.tgt_abort_tx), .perr_as_master(pins.perr_as_master),
		.own_access(pins.own_access), .gnt_n(pins.gnt_n), .boot_pci(boot_pci),
		.host_mode(host_mode), .serr_n_oe(serr_n_oe), .perr_n_oe(perr_n_oe),
		.end_access(end_access), .bus_master_on(bus_master_on), .mem_space_on(mem_space_on),
		.io_space_on(io_space_on), .fast_b2b_on(fast_b2b_on), .mwi_on(mwi_on),
		.cache_line_size(cache_line_size), .sat_status(sat_status));
	pcfg_pci_agent u_pcfg_pci_agent (.ev_req(ev_req), .ev_go(ev_go), .pins(pins), .busy(busy));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic next_rand(output logic [31:0] r);
		seed = lfsr(seed);
		r[31:16] = seed;
		seed = lfsr(seed);
		r[15:0] = seed;
	endtask : next_rand

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// hold one event across pci edges, noting any serr or perr drive meanwhile
	task automatic pci_ev(input logic [13:0] e, output logic s, output logic p);
		int i;
		i = 0;
		s = 1'b0;
		p = 1'b0;
		@(posedge ref_clk);
		ev_req <= pcfg_pin_t'(e);
		ev_go <= 1'b1;
		while (busy || i < 12) begin
			@(posedge ref_clk);
			s = s | serr_n_oe;
			p = p | perr_n_oe;
			if (i == 9)
				ev_go <= 1'b0;
			i++;
		end
		repeat (4) @(posedge ref_clk);
	endtask : pci_ev

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		if (rd_seen)
			chk(reg_rdata, exp_q.pop_front());
		rd_seen <= reg_rd;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(32'(bus_master_on), 32'h1);
		rd(ADDR_STATUS_CMD, STATUS_FIXED | 32'h4);
		rd(ADDR_CLASS_REV, {CLASS_RESET, REV_RESET});
		rd(ADDR_HDR_MISC, 32'h0);
		rd(16'hd010, 32'h0);
		wr(ADDR_STATUS_CMD, 32'hffffffff);
		rd(ADDR_STATUS_CMD, STATUS_FIXED | 32'h0357);
		chk(32'({bus_master_on, mem_space_on, io_space_on, fast_b2b_on, mwi_on}), 32'h1f);
		$display("test reset and command done");
		for (int i = 0; i < 13; i++) begin
			t = EV_TBL[i];
			wr(ADDR_STATUS_CMD, STATUS_W1C_MASK | 32'(t[23:8]));
			pci_ev(t[37:24], sv, pv);
			st = STATUS_FIXED | {t[7:0], 24'h0} | 32'(t[23:8]);
			rd(ADDR_STATUS_CMD, st);
			chk(32'(sv), 32'(t[6]));
			chk(32'(pv), 32'((t[36] | t[35]) & t[14]));
			chk(32'(sat_status), 32'(st[31:16]));
		end
		$display("test status events done");
		@(posedge ref_clk);
		satellite_mode <= 1'b1;
		wr(ADDR_STATUS_CMD, 32'h00000357);
		rd(ADDR_STATUS_CMD, 32'h0);
		rd(ADDR_CLASS_REV, 32'h0);
		@(posedge ref_clk);
		satellite_mode <= 1'b0;
		rd(ADDR_STATUS_CMD, st);
		$display("test satellite done");
		next_rand(r1);
		wr(ADDR_LOAD_WORD1, r1);
		wr(ADDR_CLASS_REV, r1);
		rd(ADDR_CLASS_REV, {CLASS_RESET, REV_RESET});
		config_load_window <= 1'b1;
		wr(ADDR_LOAD_WORD1, r1);
		config_load_window <= 1'b0;
		rd(ADDR_CLASS_REV, r1);
		next_rand(r2);
		next_rand(r3);
		wr(ADDR_HDR_MISC, r3);
		wr(ADDR_LOAD_WORD3, r2);
		rd(ADDR_HDR_MISC, r3 & 32'h0000fcff);
		chk(32'(cache_line_size), 32'(r3[7:0]));
		config_load_pending <= 1'b1;
		wr(ADDR_LOAD_WORD3, r2);
		config_load_pending <= 1'b0;
		rd(ADDR_HDR_MISC, (r3 & 32'h0000fcff) | (r2 & 32'h007f0000));
		$display("test loads done");
		wr(ADDR_HDR_MISC, 32'h00000400);
		@(posedge ref_clk);
		ev_req <= pcfg_pin_t'(14'h000c);
		ev_go <= 1'b1;
		repeat (3) @(posedge pins.clk);
		repeat (2) @(posedge ref_clk);
		chk(32'(end_access), 32'h0);
		repeat (5) @(posedge pins.clk);
		repeat (6) @(posedge ref_clk);
		chk(32'(end_access), 32'h1);
		ev_go <= 1'b0;
		while (busy)
			@(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		chk(32'(end_access), 32'h0);
		$display("test latency done");
		host_mode <= 1'b0;
		rst_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(32'({bus_master_on, mem_space_on, io_space_on, fast_b2b_on, mwi_on}), 32'h0);
		rd(ADDR_STATUS_CMD, STATUS_FIXED);
		rd(ADDR_CLASS_REV, {CLASS_RESET, REV_RESET});
		rd(ADDR_HDR_MISC, 32'h0);
		$display("test second reset done");
		repeat (4) @(posedge ref_clk);
		end_of_test();
	end
endmodule : tb
